// file: hdl/fst_frame_ctrl.sv
`timescale 1ns/100ps
`include "fst_defines.svh"
// Functional notes
// R1 - three modes; free running is default and streams frames back to back
// R2 - external trigger starts one frame; triggers ignored until frame time elapses
// R3 - triggered frame period is the longer of frame time and trigger period; the code waits for the first trigger after the frame ends
// R4 - no frame is ever shorter than the timing-0 readout
// R5 - grabber makes periodic triggers, up to 5 s, 1 us resolution
// R6 - grabber frame-sync pulses handled exactly like external triggers
// R7 - external trigger is a 20 us active-low pulse
// R8 - triggers accepted from direct input and from grabber frame-sync line
// R9 - triggers act only while a trigger mode is selected
// R10 - each frame start gives a 62.5 ns active-low frame-start pulse; the code gives one 100 ns clock cycle
// R11 - longer timings: timing-0 readout then delay of the remainder, integrating
// R12 - timing 0 reads every pixel once per frame, no delay
// R13 - split-row variants spend the whole frame on readout
// R14 - operator keeps integration time below the trigger period
// R15 - entering internal trigger mode aborts the frame and waits idle
// R16 - trigger inputs synchronised, recognised on the falling edge

module fst_frame_ctrl
   import fst_pkg::*;
#(
   parameter int CNT_W = `FST_CNT_W
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // mode and timing selection
   input  wire fst_mode_e        mode_sel,
   input  wire logic [CNT_W-1:0] readout_cycles,
   input  wire logic [CNT_W-1:0] frame_cycles,
   input  wire logic             split_rows,
   // trigger pins
   input  wire logic             ext_trigger_in_n,
   input  wire logic             grabber_frame_sync_n,
   // frame status
   output      logic             frame_start_pulse_n,
   output      logic             readout_active,
   output      logic             integrating
);

   localparam logic [`FST_PULSE_W-1:0] PULSE_CYC = `FST_PULSE_W'(`FST_START_PULSE_CYC);

   if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("fst_frame_ctrl: CNT_W must lie in 2..32");
   end

   typedef struct packed {
      fst_state_e              st;
      fst_mode_e               mode;
      logic [CNT_W-1:0]        cnt;
      logic [CNT_W-1:0]        flen;
      logic [CNT_W-1:0]        rlen;
      logic [`FST_PULSE_W-1:0] pulse_left;
      logic                    pulse_n;
      logic                    readout;
      logic                    integ;
   } fst_ctrl_s;

   fst_ctrl_s q;
   fst_ctrl_s d;

   logic ext_fall;
   logic grab_fall;
   logic trig;
   logic trig_mode;
   logic fend;
   logic start;
   logic [CNT_W-1:0] rd_len;
   logic [CNT_W-1:0] eff_len;

   function automatic logic [CNT_W-1:0] fst_max(input logic [CNT_W-1:0] a,
                                                input logic [CNT_W-1:0] b);
      fst_max = (a > b) ? a : b;
   endfunction : fst_max

   fst_trig_sync u_ext_sync (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ext_trigger_in_n_n (ext_trigger_in_n),
      .trig_fall (ext_fall)
   );

   fst_trig_sync u_grab_sync (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ext_trigger_in_n_n (grabber_frame_sync_n),
      .trig_fall (grab_fall)
   );

   always_comb begin
      d         = q;
      start     = 1'b0;
      trig      = ext_fall || grab_fall; // R8 R6
      trig_mode = (mode_sel == FST_MODE_EXT) || (mode_sel == FST_MODE_INT);
      // a zero readout setting would stall the counter, so one cycle is the floor
      rd_len    = fst_max(readout_cycles, CNT_W'(1));
      eff_len   = fst_max(frame_cycles, rd_len); // R4 R12
      fend      = (q.st != FST_ST_IDLE) && (q.cnt == q.flen - 1'b1);
      if (mode_sel == FST_MODE_INT && q.mode != FST_MODE_INT) begin
         d.st  = FST_ST_IDLE; // R15
         d.cnt = '0;
      end else begin
         unique case (q.st)
            FST_ST_IDLE: begin
               if (mode_sel == FST_MODE_FREE || mode_sel == FST_MODE_RSVD) begin
                  start = 1'b1; // R1
               end else if (trig && trig_mode) begin
                  start = 1'b1; // R2 R9
               end
            end
            FST_ST_READ, FST_ST_DELAY: begin
               // triggers inside a frame fall through here unused
               d.cnt = q.cnt + 1'b1; // R2 R3
               if (q.st == FST_ST_READ && q.cnt == q.rlen - 1'b1) begin
                  d.st = FST_ST_DELAY; // R11
               end
               if (fend) begin
                  if (trig_mode) begin
                     d.st = FST_ST_IDLE; // R2
                  end else begin
                     start = 1'b1; // R1
                  end
               end
            end
            default: begin
               d.st = FST_ST_IDLE;
            end
         endcase
      end
      if (start) begin
         d.st         = FST_ST_READ;
         d.cnt        = '0;
         d.flen       = eff_len;
         d.rlen       = split_rows ? eff_len : rd_len; // R13 R11
         d.pulse_left = PULSE_CYC; // R10
      end else if (q.pulse_left != '0) begin
         d.pulse_left = q.pulse_left - 1'b1;
      end
      d.mode    = mode_sel;
      d.pulse_n = (d.pulse_left == '0); // R10
      d.readout = (d.st == FST_ST_READ);
      d.integ   = (d.st == FST_ST_DELAY); // R11
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '{st: FST_ST_IDLE, mode: FST_MODE_FREE, cnt: '0, flen: '0, rlen: '0,
                pulse_left: '0, pulse_n: 1'b1, readout: 1'b0, integ: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign frame_start_pulse_n = q.pulse_n;
   assign readout_active      = q.readout;
   assign integrating         = q.integ;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_frame_begin;
      !frame_start_pulse_n && readout_active;
   endsequence

   sequence s_frame_end;
      (q.st != FST_ST_IDLE) && (q.cnt == q.flen - 1'b1);
   endsequence

   a_pulse_width: assert property ($fell(frame_start_pulse_n) |=> frame_start_pulse_n) // R10
      else $error("frame-start pulse not one cycle wide");
   a_pulse_at_start: assert property (!frame_start_pulse_n |-> s_frame_begin ##0 (q.cnt == '0)) // R10
      else $error("frame-start pulse outside a frame start");
   a_free_restart: assert property (s_frame_end // R1
                                    ##0 (mode_sel == FST_MODE_FREE && q.mode == mode_sel)
                                    |=> s_frame_begin)
      else $error("free running did not restart the next frame");
   a_trig_ignored: assert property ((q.st != FST_ST_IDLE) && !fend && trig // R2
                                    |=> frame_start_pulse_n)
      else $error("trigger inside a frame restarted it");
   a_trig_starts: assert property ((q.st == FST_ST_IDLE) && trig && mode_sel == FST_MODE_EXT // R2
                                   && q.mode == FST_MODE_EXT |=> s_frame_begin)
      else $error("trigger in idle did not start a frame");
   a_trig_mode_only: assert property ((q.st == FST_ST_IDLE) && !trig && trig_mode // R9
                                      |=> frame_start_pulse_n)
      else $error("frame started without a trigger");
   a_readout_len: assert property ($rose(integrating) |-> $past(q.cnt) == q.rlen - 1'b1) // R11
      else $error("readout phase length wrong");
   a_min_frame: assert property ((q.st != FST_ST_IDLE) |-> q.flen >= q.rlen && q.rlen != '0) // R4
      else $error("frame shorter than readout");
   // a trigger in the first idle cycle may legally start the next frame at once
   a_int_abort: assert property ((mode_sel == FST_MODE_INT) && (q.mode != FST_MODE_INT) // R15
                                 |=> (q.st == FST_ST_IDLE) && !readout_active
                                     && frame_start_pulse_n
                                 ##1 ((q.st == FST_ST_IDLE) || !frame_start_pulse_n))
      else $error("entering internal trigger did not abort to idle");
   a_split_rows: assert property (s_frame_begin ##0 $past(split_rows) |-> q.rlen == q.flen) // R13
      else $error("split-row frame has a delay phase");

endmodule : fst_frame_ctrl

// file: hdl/fst_trig_sync.sv
`timescale 1ns/100ps

module fst_trig_sync
   import fst_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // asynchronous active-low trigger
   input  wire logic ext_trigger_in_n_n,
   // one-cycle falling edge
   output      logic trig_fall
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic fall;
   } fst_sync_s;

   fst_sync_s q;
   fst_sync_s d;

   always_comb begin
      d      = q;
      d.s1   = ext_trigger_in_n_n;
      d.s2   = q.s1;
      d.s3   = q.s2;
      d.fall = 1'b0;
      // level only moves once the second and third stage agree
      if (q.s2 == q.s3) begin
         d.lvl  = q.s3;
         d.fall = q.lvl && !q.s3; // R16
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1, fall: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign trig_fall = q.fall;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_fall_single: assert property (trig_fall |=> !trig_fall) // R16
      else $error("trigger edge lasted more than one cycle");
   a_fall_level: assert property (trig_fall |-> !q.lvl && $past(q.lvl)) // R16
      else $error("trigger edge without a high to low level change");

endmodule : fst_trig_sync

// file: inc/fst_defines.svh
`ifndef FST_DEFINES_SVH
`define FST_DEFINES_SVH

// device clock
`define FST_CLK_PERIOD_PS   100000
// frame-start pulse width, 62.5 ns held in picoseconds
`define FST_START_PULSE_PS  62500
// a longest time rounds down, but never below one cycle
`define FST_START_PULSE_CYC \
   (((`FST_START_PULSE_PS / `FST_CLK_PERIOD_PS) > 0) ? \
    (`FST_START_PULSE_PS / `FST_CLK_PERIOD_PS) : 1)
// width of the pulse counter
`define FST_PULSE_W         4
// default width of the frame counters
`define FST_CNT_W           32

`endif

// file: inc/fst_pkg.sv
package fst_pkg;

   // acquisition control mode
   typedef enum logic [1:0] {
      FST_MODE_FREE,
      FST_MODE_EXT,
      FST_MODE_INT,
      FST_MODE_RSVD
   } fst_mode_e;

   // frame sequencer state
   typedef enum logic [1:0] {
      FST_ST_IDLE,
      FST_ST_READ,
      FST_ST_DELAY
   } fst_state_e;

endpackage : fst_pkg

// file: verification/fst_frame_ctrl_test.sv
`timescale 1ns/100ps

module fst_frame_ctrl_test
   import fst_pkg::*;
;
   logic        clk            = 1'b0;
   logic        sys_rst        = 1'b1;
   fst_mode_e   mode_sel       = FST_MODE_FREE;
   logic [31:0] readout_cycles = 32'h64;
   logic [31:0] frame_cycles   = 32'h12C;
   logic        split_rows     = 1'b0;
   logic        ext_req        = 1'b0;
   logic [31:0] sync_period    = 32'h0;
   logic        ext_trigger_in_n;
   logic        grabber_frame_sync_n;
   logic        frame_start_pulse_n;
   logic        readout_active;
   logic        integrating;
   int          mismatches     = 0;
   int          cmp_count      = 0;
   int          n;

   fst_frame_ctrl uut (.clk(clk), .sys_rst(sys_rst), .mode_sel(mode_sel),
      .readout_cycles(readout_cycles), .frame_cycles(frame_cycles), .split_rows(split_rows),
      .ext_trigger_in_n(ext_trigger_in_n), .grabber_frame_sync_n(grabber_frame_sync_n),
      .frame_start_pulse_n(frame_start_pulse_n), .readout_active(readout_active),
      .integrating(integrating));
   fst_grabber_model grabber (.clk(clk), .ext_req(ext_req), .sync_period(sync_period),
      .ext_trigger_in_n(ext_trigger_in_n), .grabber_frame_sync_n(grabber_frame_sync_n));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic step;
      @(posedge clk);
      #1;
   endtask : step

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic complete_run;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   // cycles until the next frame-start pulse, bounded
   task automatic next_start(output int c);
      c = 0;
      do begin
         step;
         c++;
      end while (frame_start_pulse_n !== 1'b0 && c < 2000);
      if (c >= 2000) begin
         mismatches++;
         complete_run;
      end
   endtask : next_start

   // called in the pulse cycle; counts readout then delay cycles
   task automatic meas_frame(output int r, output int g);
      r = 0;
      g = 0;
      // with no delay phase readout runs on into the next frame, so its pulse ends the count
      while (readout_active === 1'b1 && (r == 0 || frame_start_pulse_n === 1'b1)
             && r < 5000) begin
         r++;
         step;
         if (r == 1) chk(32'(frame_start_pulse_n), 32'h1);
      end
      while (integrating === 1'b1 && g < 5000) begin
         g++;
         step;
      end
      if (r >= 5000 || g >= 5000) begin
         mismatches++;
         complete_run;
      end
   endtask : meas_frame

   task automatic quiet(input int k);
      int c;
      c = 0;
      repeat (k) begin
         step;
         if (frame_start_pulse_n !== 1'b1) c++;
      end
      chk(32'(c), 32'h0);
   endtask : quiet

   task automatic fire;
      @(posedge clk);
      ext_req <= 1'b1;
      @(posedge clk);
      ext_req <= 1'b0;
   endtask : fire

   // lengths latch at frame start, so the first frame after a change is skipped
   task automatic t_free(input int fl, input logic sp, input int er, input int eg);
      int r;
      int g;
      @(posedge clk);
      frame_cycles <= 32'(fl);
      split_rows   <= sp;
      next_start(n);
      next_start(n);
      meas_frame(r, g);
      chk(32'(r), 32'(er));
      chk(32'(g), 32'(eg));
      chk(32'(frame_start_pulse_n), 32'h0);
   endtask : t_free

   task automatic t_int;
      int p;
      next_start(n);
      repeat (50) step;
      @(posedge clk);
      mode_sel <= FST_MODE_INT;
      repeat (3) step;
      chk(32'(readout_active), 32'h0);
      chk(32'(integrating), 32'h0);
      quiet(200);
      // frame of 300 cycles: sync every 400 or every 200 both give 400
      for (p = 400; p >= 200; p -= 200) begin
         @(posedge clk);
         sync_period <= 32'(p);
         next_start(n);
         next_start(n);
         chk(32'(n), 32'h190);
      end
   endtask : t_int

   task automatic t_ext;
      @(posedge clk);
      sync_period <= 32'h0;
      mode_sel    <= FST_MODE_EXT;
      repeat (450) step;
      quiet(500);
      fire;
      next_start(n);
      chk(32'(n >= 3 && n <= 9), 32'h1);
      repeat (250) step;
      fire;
      quiet(400);
      fire;
      next_start(n);
      chk(32'(n <= 9), 32'h1);
   endtask : t_ext

   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_free(100, 1'b0, 100, 0);
      t_free(300, 1'b1, 300, 0);
      t_free(300, 1'b0, 100, 200);
      t_int;
      t_ext;
      complete_run;
   end
endmodule : fst_frame_ctrl_test

// file: verification/fst_grabber_model.sv
`timescale 1ns/100ps

module fst_grabber_model #(
   parameter int EXT_LOW  = 200, // 20 us at the 10 MHz device clock
   parameter int SYNC_LOW = 20   // frame-sync width, our own choice
)
(
   // clock
   input  wire logic        clk,
   // stimulus control
   input  wire logic        ext_req,
   input  wire logic [31:0] sync_period,
   // trigger lines, idle high
   output      logic        ext_trigger_in_n,
   output      logic        grabber_frame_sync_n
);
   int ext_cnt  = 0;
   int sync_cnt = 0;

   // a request while the pin is still low only stretches it, no new edge
   always @(posedge clk) begin
      if (ext_req) begin
         ext_cnt <= EXT_LOW;
      end else if (ext_cnt > 0) begin
         ext_cnt <= ext_cnt - 1;
      end
      if (sync_period == 32'h0 || sync_cnt >= int'(sync_period) - 1) begin
         sync_cnt <= 0;
      end else begin
         sync_cnt <= sync_cnt + 1;
      end
   end

   assign ext_trigger_in_n     = (ext_cnt == 0);
   assign grabber_frame_sync_n = !(sync_period != 32'h0 && sync_cnt < SYNC_LOW);
endmodule : fst_grabber_model
